// [design/sdmd_pkg.sv]
// Shared constants for the register decode and data-move block.
// Assumes a single 20 MHz core clock and the CPU core as the only requester.
package sdmd_pkg;

  // Register addresses in the direct-address register space
  localparam logic [7:0] ADDR_P0 = 8'h80;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL0 = 8'h82;
  localparam logic [7:0] ADDR_DPH0 = 8'h83;
  localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
  localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_PSEL = 8'h86;
  localparam logic [7:0] ADDR_PCON = 8'h87;
  localparam logic [7:0] ADDR_P4SEL = 8'ha2;
  localparam logic [7:0] ADDR_PMR = 8'hc4;

  // Reset values
  localparam logic [7:0] RST_P0 = 8'hff;
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] UNIMPL_READ = 8'hff;

  // Field positions and implemented-bit masks
  localparam int PCON_IDLE_BIT = 0;
  localparam int PCON_PD_BIT = 1;
  localparam logic [7:0] PCON_IMPL = 8'hcf;
  localparam int PMR_XRAM_EN_BIT = 0;
  localparam int PMR_ECON_LSB = 6;
  localparam logic [7:0] PMR_IMPL = 8'hc1;
  localparam int P4SEL_PULLUP_BIT = 3;
  localparam int PSEL_BIT = 0;

  // Data-move address map
  localparam int XRAM_AW = 10;
  localparam logic [15:0] XRAM_TOP = 16'h03ff;

  // Timing in core ticks
  localparam int CLKS_PER_MC = 4;
  localparam int XRAM_MC = 2;
  localparam int EXT_BASE_MC = 2;
  localparam logic [5:0] XRAM_TICKS = 6'(XRAM_MC * CLKS_PER_MC);
  localparam logic [5:0] ALE_TICKS = 6'(CLKS_PER_MC / 2);

  // Economy divider settings, the enum value is the register field code
  typedef enum logic [1:0] {ECON_FULL, ECON_DIV4, ECON_DIV64, ECON_DIV1024} sdmd_econ_t;
  localparam logic [10:0] DIV_FULL = 11'h001;
  localparam logic [10:0] DIV_A = 11'h004;
  localparam logic [10:0] DIV_B = 11'h040;
  localparam logic [10:0] DIV_C = 11'h400;

  // Only addresses ending in 0 or 8 accept single-bit operations
  function automatic logic bit_capable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction : bit_capable

  // Total external data-move length in ticks for a stretch setting
  function automatic logic [5:0] ext_ticks(input logic [2:0] s);
    return 6'((EXT_BASE_MC + int'(s)) * CLKS_PER_MC);
  endfunction : ext_ticks

endpackage : sdmd_pkg

// [design/sdmd_clkgen.sv]
// Clock-enable generator for economy, idle and power-down modes.
// Assumes sys_clk is the oscillator; all downstream logic uses the enables.
`timescale 1ns/100ps
`default_nettype none
module sdmd_clkgen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] econ_sel,
  input wire logic idle,
  input wire logic pdown,
  output logic core_en,
  output logic periph_en
);

  logic [9:0] cnt_q, cnt_d;
  logic core_d, periph_d;
  logic [10:0] limit;
  logic tick;

  // Divider period from the economy field
  always_comb begin
    case (sdmd_pkg::sdmd_econ_t'(econ_sel))
      sdmd_pkg::ECON_DIV4: limit = sdmd_pkg::DIV_A;
      sdmd_pkg::ECON_DIV64: limit = sdmd_pkg::DIV_B;
      sdmd_pkg::ECON_DIV1024: limit = sdmd_pkg::DIV_C;
      default: limit = sdmd_pkg::DIV_FULL;
    endcase
    tick = ({1'b0, cnt_q} >= (limit - 11'h001));
    cnt_d = tick ? 10'h000 : cnt_q + 10'h001;
    // Power-down freezes the divider too, so nothing toggles at all
    if (pdown) begin
      cnt_d = cnt_q;
    end
    core_d = tick && !idle && !pdown;
    periph_d = tick && !pdown;
  end

  // Registered enables keep the downstream fan-out glitch free
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 10'h000;
      core_en <= 1'b0;
      periph_en <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      core_en <= core_d;
      periph_en <= periph_d;
    end
  end

  idle_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (idle || pdown) |=> !core_en) else $error("core enable during idle");
  pd_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pdown |=> !periph_en) else $error("peripheral enable in power-down");
  // One cycle of an undisturbed divide-by-4 run
  sequence s_div4_run;
    econ_sel == sdmd_pkg::ECON_DIV4 && !pdown && !idle;
  endsequence
  // A tick restarts the divider, so the next one must come exactly four edges later
  div4_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_en ##0 s_div4_run ##1 s_div4_run [*3] |=> core_en && !$past(core_en, 1) &&
    !$past(core_en, 2) && !$past(core_en, 3)) else $error("divide-by-4 period wrong");

endmodule : sdmd_clkgen
`default_nettype wire

// [design/sdmd_xram.sv]
// On-chip data-move SRAM, one write port and a registered read.
// Assumes the caller holds address and data steady for the access.
`timescale 1ns/100ps
`default_nettype none
module sdmd_xram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  // Storage kept apart from the scratchpad, reached only by data moves
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array; contents are undefined after power-up
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : sdmd_xram
`default_nettype wire

// [design/sdmd_top.sv]
// Register decode, data pointers, power modes and data-move routing.
// Assumes the core presents one request at a time and holds it until taken.
`timescale 1ns/100ps
`default_nettype none
module sdmd_top #(
  parameter int XRAM_AW = sdmd_pkg::XRAM_AW
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sfr_req,
  input wire logic sfr_wr,
  input wire logic sfr_direct,
  input wire logic sfr_bit,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_value,
  input wire logic sp_load,
  input wire logic [7:0] sp_value,
  input wire logic xmove_req,
  input wire logic xmove_wr,
  input wire logic [15:0] xmove_addr,
  input wire logic [7:0] xmove_wdata,
  input wire logic [2:0] ext_stretch,
  input wire logic wake,
  input wire logic [7:0] p0_in,
  output logic [7:0] sfr_rdata,
  output logic sfr_ack,
  output logic sfr_bit_ok,
  output logic scratch_hit,
  output logic [15:0] active_data_pointer,
  output logic [7:0] stack_pointer,
  output logic [7:0] xmove_rdata,
  output logic xmove_done,
  output logic xmove_busy,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  output logic port0_pullup_enable,
  output logic [7:0] p2_out,
  output logic p2_oe_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic core_clk_en,
  output logic periph_clk_en
);

  typedef enum logic [1:0] {X_IDLE, X_ONCHIP, X_EXT} sdmd_xstate_t;

  logic [7:0] p0_q, p0_d, dpl0_q, dpl0_d, dph0_q, dph0_d, pointer1_low_q, pointer1_low_d;
  logic [7:0] pointer1_high_q, pointer1_high_d, pcon_q, pcon_d, pmr_q, pmr_d, p4sel_q, p4sel_d;
  logic [7:0] sp_d, rdata_d, latch_img, new_val;
  logic pointer_select_q, pointer_select_d;
  logic ack_d, bit_ok_d, scratch_d;
  logic [15:0] ptr_d;
  logic take_sfr, sfr_write;
  logic onchip_xram_enable;
  sdmd_xstate_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d, total_q, total_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d, rbuf_q, rbuf_d, xram_rdata;
  logic wr_q, wr_d, done_d, busy_d, ale_d, rd_n_d, wr_n_d, p2_oe_n_d;
  logic [7:0] p0_out_d, p0_oe_n_d, p2_out_d, xrdata_d;
  logic xram_we, pullup_d;

  assign onchip_xram_enable = pmr_q[sdmd_pkg::PMR_XRAM_EN_BIT];

  // Read image of a register; pins for port 0 on a byte read, latch for bit RMW
  function automatic logic [7:0] reg_image(input logic [7:0] a, input logic pins);
    case (a)
      sdmd_pkg::ADDR_P0: reg_image = pins ? p0_in : p0_q;
      sdmd_pkg::ADDR_SP: reg_image = stack_pointer;
      sdmd_pkg::ADDR_DPL0: reg_image = dpl0_q;
      sdmd_pkg::ADDR_DPH0: reg_image = dph0_q;
      sdmd_pkg::ADDR_POINTER1_LOW: reg_image = pointer1_low_q;
      sdmd_pkg::ADDR_POINTER1_HIGH: reg_image = pointer1_high_q;
      sdmd_pkg::ADDR_PSEL: reg_image = {7'h00, pointer_select_q};
      sdmd_pkg::ADDR_PCON: reg_image = pcon_q | ~sdmd_pkg::PCON_IMPL;
      sdmd_pkg::ADDR_PMR: reg_image = pmr_q | ~sdmd_pkg::PMR_IMPL;
      sdmd_pkg::ADDR_P4SEL: reg_image = p4sel_q;
      default: reg_image = sdmd_pkg::UNIMPL_READ;
    endcase
  endfunction : reg_image

  ////////////////////////////////////////////////////////////////////////////
  // Register file: next values
  always_comb begin
    // Requests are only taken on core clock ticks, so idle freezes them
    take_sfr = sfr_req && core_clk_en;
    // Indirect access above 7Fh never touches registers
    scratch_d = take_sfr && sfr_addr[7] && !sfr_direct;
    bit_ok_d = take_sfr && sfr_direct && sfr_bit && sdmd_pkg::bit_capable(sfr_addr);
    sfr_write = take_sfr && sfr_direct && sfr_addr[7] && sfr_wr && (!sfr_bit || bit_ok_d);
    latch_img = reg_image(sfr_addr, 1'b0);
    new_val = sfr_wdata;
    if (sfr_bit) begin
      new_val = latch_img;
      new_val[sfr_bit_idx] = sfr_wdata[0];
    end
    p0_d = p0_q;
    sp_d = stack_pointer;
    dpl0_d = dpl0_q;
    dph0_d = dph0_q;
    pointer1_low_d = pointer1_low_q;
    pointer1_high_d = pointer1_high_q;
    pointer_select_d = pointer_select_q;
    pcon_d = pcon_q;
    pmr_d = pmr_q;
    p4sel_d = p4sel_q;
    // Core-side pointer and stack updates; a register write in the same tick wins
    if (sp_load && core_clk_en) begin
      sp_d = sp_value;
    end
    if (ptr_load && core_clk_en) begin
      if (pointer_select_q) begin
        {pointer1_high_d, pointer1_low_d} = ptr_value;
      end else begin
        {dph0_d, dpl0_d} = ptr_value;
      end
    end
    if (sfr_write) begin
      case (sfr_addr)
        sdmd_pkg::ADDR_P0: p0_d = new_val;
        sdmd_pkg::ADDR_SP: sp_d = new_val;
        sdmd_pkg::ADDR_DPL0: dpl0_d = new_val;
        sdmd_pkg::ADDR_DPH0: dph0_d = new_val;
        sdmd_pkg::ADDR_POINTER1_LOW: pointer1_low_d = new_val;
        sdmd_pkg::ADDR_POINTER1_HIGH: pointer1_high_d = new_val;
        sdmd_pkg::ADDR_PSEL: pointer_select_d = new_val[sdmd_pkg::PSEL_BIT];
        sdmd_pkg::ADDR_PCON: pcon_d = new_val & sdmd_pkg::PCON_IMPL;
        sdmd_pkg::ADDR_PMR: pmr_d = new_val & sdmd_pkg::PMR_IMPL;
        sdmd_pkg::ADDR_P4SEL: p4sel_d = new_val;
        default: ;
      endcase
    end
    // A wake event ends idle and power-down
    if (wake) begin
      pcon_d[sdmd_pkg::PCON_IDLE_BIT] = 1'b0;
      pcon_d[sdmd_pkg::PCON_PD_BIT] = 1'b0;
    end
    ack_d = take_sfr && !sfr_wr;
    rdata_d = sfr_rdata;
    if (ack_d) begin
      rdata_d = reg_image(sfr_addr, 1'b1);
      if (sfr_bit) begin
        rdata_d = {7'h00, bit_ok_d & latch_img[sfr_bit_idx]};
      end
      if (scratch_d || !sfr_addr[7]) begin
        rdata_d = sdmd_pkg::RST_ZERO;
      end
    end
    ptr_d = pointer_select_d ? {pointer1_high_d, pointer1_low_d} : {dph0_d, dpl0_d};
    pullup_d = p4sel_d[sdmd_pkg::P4SEL_PULLUP_BIT];
  end

  // Register file: storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_q <= sdmd_pkg::RST_P0;
      stack_pointer <= sdmd_pkg::RST_SP;
      dpl0_q <= sdmd_pkg::RST_ZERO;
      dph0_q <= sdmd_pkg::RST_ZERO;
      pointer1_low_q <= sdmd_pkg::RST_ZERO;
      pointer1_high_q <= sdmd_pkg::RST_ZERO;
      pointer_select_q <= 1'b0;
      pcon_q <= sdmd_pkg::RST_ZERO;
      pmr_q <= sdmd_pkg::RST_ZERO;
      p4sel_q <= sdmd_pkg::RST_ZERO;
      sfr_rdata <= sdmd_pkg::RST_ZERO;
      sfr_ack <= 1'b0;
      sfr_bit_ok <= 1'b0;
      scratch_hit <= 1'b0;
      active_data_pointer <= 16'h0000;
      port0_pullup_enable <= 1'b0;
    end else begin
      p0_q <= p0_d;
      stack_pointer <= sp_d;
      dpl0_q <= dpl0_d;
      dph0_q <= dph0_d;
      pointer1_low_q <= pointer1_low_d;
      pointer1_high_q <= pointer1_high_d;
      pointer_select_q <= pointer_select_d;
      pcon_q <= pcon_d;
      pmr_q <= pmr_d;
      p4sel_q <= p4sel_d;
      sfr_rdata <= rdata_d;
      sfr_ack <= ack_d;
      sfr_bit_ok <= bit_ok_d;
      scratch_hit <= scratch_d;
      active_data_pointer <= ptr_d;
      port0_pullup_enable <= pullup_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock modes
  sdmd_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .econ_sel(pmr_q[sdmd_pkg::PMR_ECON_LSB +: 2]),
    .idle(pcon_q[sdmd_pkg::PCON_IDLE_BIT]),
    .pdown(pcon_q[sdmd_pkg::PCON_PD_BIT]),
    .core_en(core_clk_en),
    .periph_en(periph_clk_en)
  );

  // On-chip data-move memory
  sdmd_xram #(.AW(XRAM_AW), .DW(8)) u_xram (
    .sys_clk(sys_clk),
    .we(xram_we),
    .addr(addr_q[XRAM_AW-1:0]),
    .wdata(wdat_q),
    .rdata(xram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data-move sequencer: next values; ticks advance on core clock enables
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    total_d = total_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    wr_d = wr_q;
    rbuf_d = rbuf_q;
    done_d = 1'b0;
    xrdata_d = xmove_rdata;
    xram_we = (state_q == X_ONCHIP) && wr_q && (cnt_q == 6'h00) && core_clk_en;
    case (state_q)
      X_IDLE: begin
        if (xmove_req && core_clk_en) begin
          addr_d = xmove_addr;
          wdat_d = xmove_wdata;
          wr_d = xmove_wr;
          cnt_d = 6'h00;
          // Low 1 KB goes on chip only while enabled; all else goes out
          if (onchip_xram_enable && xmove_addr <= sdmd_pkg::XRAM_TOP) begin
            state_d = X_ONCHIP;
            total_d = sdmd_pkg::XRAM_TICKS;
          end else begin
            state_d = X_EXT;
            total_d = sdmd_pkg::ext_ticks(ext_stretch);
          end
        end
      end
      X_ONCHIP, X_EXT: begin
        if (core_clk_en) begin
          cnt_d = cnt_q + 6'h01;
          // Read data is taken while the strobe is still low
          if (state_q == X_EXT && cnt_q == total_q - 6'h02) begin
            rbuf_d = p0_in;
          end
          if (cnt_q == total_q - 6'h01) begin
            state_d = X_IDLE;
            done_d = 1'b1;
            xrdata_d = (state_q == X_ONCHIP) ? xram_rdata : rbuf_q;
          end
        end
      end
      default: state_d = X_IDLE;
    endcase
    busy_d = (state_d != X_IDLE);
    // Port pins follow the next sequencer state so outputs stay registered
    ale_d = 1'b0;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    p2_out_d = 8'hff;
    p2_oe_n_d = 1'b1;
    p0_out_d = 8'h00;
    p0_oe_n_d = p0_d;
    if (state_d == X_EXT) begin
      p2_out_d = addr_d[15:8];
      p2_oe_n_d = 1'b0;
      p0_oe_n_d = 8'h00;
      if (cnt_d < 6'(sdmd_pkg::CLKS_PER_MC)) begin
        p0_out_d = addr_d[7:0];
        ale_d = (cnt_d < sdmd_pkg::ALE_TICKS);
      end else begin
        p0_out_d = wdat_d;
        p0_oe_n_d = wr_d ? 8'h00 : 8'hff;
        rd_n_d = wr_d || (cnt_d == total_d - 6'h01);
        wr_n_d = !wr_d || (cnt_d == total_d - 6'h01);
      end
    end
  end

  // Data-move sequencer: storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= X_IDLE;
      cnt_q <= 6'h00;
      total_q <= 6'h00;
      addr_q <= 16'h0000;
      wdat_q <= 8'h00;
      wr_q <= 1'b0;
      rbuf_q <= 8'h00;
      xmove_done <= 1'b0;
      xmove_busy <= 1'b0;
      xmove_rdata <= 8'h00;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      p2_out <= 8'hff;
      p2_oe_n <= 1'b1;
      p0_out <= 8'h00;
      p0_oe_n <= 8'hff;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      total_q <= total_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      wr_q <= wr_d;
      rbuf_q <= rbuf_d;
      xmove_done <= done_d;
      xmove_busy <= busy_d;
      xmove_rdata <= xrdata_d;
      ale <= ale_d;
      rd_n <= rd_n_d;
      wr_n <= wr_n_d;
      p2_out <= p2_out_d;
      p2_oe_n <= p2_oe_n_d;
      p0_out <= p0_out_d;
      p0_oe_n <= p0_oe_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_low;
    state_q == X_IDLE && xmove_req && core_clk_en && xmove_addr <= sdmd_pkg::XRAM_TOP;
  endsequence

  onchip_route_a: assert property (s_take_low ##0 onchip_xram_enable |=>
    state_q == X_ONCHIP) else $error("enabled low move not on chip");
  disabled_ext_a: assert property (s_take_low ##0 !onchip_xram_enable |=>
    state_q == X_EXT) else $error("disabled move not external");
  high_ext_a: assert property (state_q == X_IDLE && xmove_req && core_clk_en &&
    xmove_addr > sdmd_pkg::XRAM_TOP |=> state_q == X_EXT && !p2_oe_n
    ) else $error("high move not external");
  onchip_len_a: assert property ($rose(state_q == X_ONCHIP) |-> total_q == 6'h08
    ) else $error("on-chip move not two machine cycles");
  psel_read_a: assert property (sfr_req && core_clk_en && sfr_direct && !sfr_wr &&
    !sfr_bit && sfr_addr == 8'h86 |=> sfr_ack && sfr_rdata[7:1] == 7'h00
    ) else $error("pointer select reserved bits nonzero");
  unimpl_read_a: assert property (sfr_req && core_clk_en && sfr_direct && !sfr_wr &&
    !sfr_bit && sfr_addr == 8'h88 |=> sfr_rdata == 8'hff
    ) else $error("unimplemented location not all ones");
  indirect_a: assert property (sfr_req && core_clk_en && !sfr_direct && sfr_addr[7]
    |=> scratch_hit && $stable(p0_q) && $stable(pcon_q)
    ) else $error("indirect access touched registers");
  bit_refuse_a: assert property (sfr_req && core_clk_en && sfr_bit &&
    sfr_addr[2:0] != 3'h0 |=> !sfr_bit_ok
    ) else $error("bit operation on non bit address");
  // The pointer output is registered from next values, so it tracks the pair in the same cycle
  ptr_sel_a: assert property (pointer_select_q
    |-> active_data_pointer == {pointer1_high_q, pointer1_low_q}
    ) else $error("active pointer not second pair");
  pullup_a: assert property ($changed(p4sel_q[3]) |=>
    port0_pullup_enable == $past(p4sel_q[3], 1)
    ) else $error("port 0 pull-up enable mismatch");
  unimpl_write_a: assert property (sfr_req && core_clk_en && sfr_wr && sfr_addr == 8'h88
    && !ptr_load && !sp_load |=> $stable(active_data_pointer) && $stable(stack_pointer)
    ) else $error("unimplemented write had effect");

endmodule : sdmd_top
`default_nettype wire

// [tb/sdmd_ext_mem_model.sv]
// External data memory on the multiplexed address/data bus.
// Assumes address stands on ports 0 and 2 while the latch strobe is high.
`timescale 1ns/100ps
`default_nettype none
module sdmd_ext_mem_model (
  input wire logic sys_clk,
  input wire logic ale,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p2_out,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic drv_en,
  output logic [7:0] drv_data
);
  // Full 64 KB; unwritten bytes read unknown, scenarios read only what they wrote
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q;
  ////////////////////////////////////////////////////////////
  // Latch the full address, low byte shared with data on port 0
  always @(posedge sys_clk) begin
    if (ale) addr_q <= {p2_out, p0_out};
    if (!wr_n) mem[addr_q] <= p0_out;
    drv_data <= mem[addr_q];
  end
  // Drive only under the read strobe, so the line is free otherwise
  assign drv_en = !rd_n;
endmodule : sdmd_ext_mem_model
`default_nettype wire

// [tb/sfr_and_data_memory_decode_tb_top.sv]
// Self-checking bench: register map, pointers, data moves, clock modes.
// Assumes the external memory model answers on the bus pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfr_and_data_memory_decode_tb_top;
  logic sys_clk, rst_n, sfr_req, sfr_wr, sfr_direct, sfr_bit, ptr_load, sp_load, wake;
  logic xmove_req, xmove_wr, sfr_ack, sfr_bit_ok, scratch_hit, xmove_done, xmove_busy;
  logic port0_pullup_enable, p2_oe_n, ale, rd_n, wr_n, core_clk_en, periph_clk_en;
  logic drv_en, tick_q, hit, ok, ack, ale_seen;
  logic [2:0] sfr_bit_idx, ext_stretch;
  logic [7:0] sfr_addr, sfr_wdata, sp_value, xmove_wdata, p0_in, sfr_rdata, stack_pointer;
  logic [7:0] xmove_rdata, p0_out, p0_oe_n, p2_out, drv_data;
  logic [7:0] pat = 8'h69;
  logic [15:0] ptr_value, xmove_addr, active_data_pointer;
  int n_mismatch = 0;
  int cmp_count = 0;
  int nc, np, i, k;
  sdmd_top u_sdmd_top (
    .sys_clk, .rst_n, .sfr_req, .sfr_wr, .sfr_direct, .sfr_bit, .sfr_bit_idx, .sfr_addr,
    .sfr_wdata, .ptr_load, .ptr_value, .sp_load, .sp_value, .xmove_req, .xmove_wr,
    .xmove_addr, .xmove_wdata, .ext_stretch, .wake, .p0_in, .sfr_rdata, .sfr_ack,
    .sfr_bit_ok, .scratch_hit, .active_data_pointer, .stack_pointer, .xmove_rdata,
    .xmove_done, .xmove_busy, .p0_out, .p0_oe_n, .port0_pullup_enable, .p2_out,
    .p2_oe_n, .ale, .rd_n, .wr_n, .core_clk_en, .periph_clk_en
  );
  sdmd_ext_mem_model u_sdmd_ext_mem_model (
    .sys_clk, .ale, .p0_out, .p2_out, .rd_n, .wr_n, .drv_en, .drv_data
  );
  // Open-drain wire; a floating line toggles unless the pull-up is enabled, so no stale value survives
  assign p0_in = (~p0_oe_n & p0_out) |
    (p0_oe_n & (drv_en ? drv_data : port0_pullup_enable ? 8'hff : pat));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Tick seen at each edge, read after the edge settles
  always @(posedge sys_clk) begin
    tick_q <= core_clk_en;
    pat <= ~pat;
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step
  // Hold a request until a tick takes it; a lost tick ends the run
  task automatic take;
    int t;
    for (t = 0; t < 3000; t++) begin
      step();
      if (tick_q === 1'b1) return;
    end
    n_mismatch++;
    conclude();
  endtask : take
  task automatic sfr(input logic w, d, b, input logic [7:0] a, v);
    sfr_wr = w;
    sfr_direct = d;
    sfr_bit = b;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_req = 1'b1;
    take();
    sfr_req = 1'b0;
    {ack, ok, hit} = {sfr_ack, sfr_bit_ok, scratch_hit};
    repeat (2) begin
      step();
      {ack, ok, hit} = {ack, ok, hit} | {sfr_ack, sfr_bit_ok, scratch_hit};
    end
  endtask : sfr
  task automatic wr(input logic [7:0] a, v);
    sfr(1'b1, 1'b1, 1'b0, a, v);
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    sfr(1'b0, 1'b1, 1'b0, a, 8'h00);
    `CHK(ack, 1'b1)
    `CHK(sfr_rdata, e)
  endtask : rdc
  // One data move; checks its length in edges from the taking edge
  task automatic xm(input logic w, input logic [15:0] a, input logic [7:0] v, input int n);
    xmove_wr = w;
    xmove_addr = a;
    xmove_wdata = v;
    xmove_req = 1'b1;
    take();
    xmove_req = 1'b0;
    `CHK(xmove_busy, 1'b1)
    ale_seen = 1'b0;
    for (i = 0; i < 40 && xmove_done !== 1'b1; i++) begin
      step();
      ale_seen |= ale;
    end
    `CHK(i, n)
  endtask : xm
  task automatic cnt(input int n);
    nc = 0;
    np = 0;
    repeat (n) begin
      step();
      nc += core_clk_en;
      np += periph_clk_en;
    end
  endtask : cnt
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    `CHK(stack_pointer, sdmd_pkg::RST_SP)
    `CHK(active_data_pointer, 16'h0000)
    rdc(8'hc4, 8'h3e);
    rdc(8'h86, 8'h00);
    wr(8'h82, 8'h11);
    wr(8'h83, 8'h22);
    wr(8'h84, 8'h33);
    wr(8'h85, 8'h44);
    `CHK(active_data_pointer, 16'h2211)
    wr(8'h86, 8'hff);
    rdc(8'h86, 8'h01);
    `CHK(active_data_pointer, 16'h4433)
    ptr_value = 16'hbeef;
    ptr_load = 1'b1;
    take();
    ptr_load = 1'b0;
    rdc(8'h84, 8'hef);
    rdc(8'h85, 8'hbe);
    wr(8'h86, 8'h00);
    rdc(8'h83, 8'h22);
    sp_value = 8'h5c;
    sp_load = 1'b1;
    take();
    sp_load = 1'b0;
    rdc(8'h81, 8'h5c);
    $display("test registers done");
  endtask : t_regs
  task automatic t_odd;
    rdc(8'h88, 8'hff);
    rdc(8'h87, 8'h30);
    wr(8'h88, 8'h00);
    rdc(8'h88, 8'hff);
    sfr(1'b1, 1'b0, 1'b0, 8'h82, 8'h55);
    `CHK(hit, 1'b1)
    rdc(8'h82, 8'h11);
    sfr_bit_idx = 3'h3;
    sfr(1'b1, 1'b1, 1'b1, 8'h81, 8'h00);
    `CHK(ok, 1'b0)
    rdc(8'h81, 8'h5c);
    sfr(1'b1, 1'b1, 1'b1, 8'h80, 8'h00);
    `CHK(ok, 1'b1)
    `CHK(p0_oe_n, 8'hf7)
    sfr(1'b1, 1'b1, 1'b1, 8'h80, 8'h01);
    sfr(1'b0, 1'b1, 1'b1, 8'h80, 8'h00);
    `CHK(sfr_rdata, 8'h01)
    wr(8'ha2, 8'h08);
    `CHK(port0_pullup_enable, 1'b1)
    wr(8'ha2, 8'h00);
    `CHK(port0_pullup_enable, 1'b0)
    $display("test decode done");
  endtask : t_odd
  task automatic t_bus;
    ext_stretch = 3'h1;
    xm(1'b1, 16'h03ff, 8'h5a, 12);
    `CHK(ale_seen, 1'b1)
    ext_stretch = 3'h0;
    xm(1'b1, 16'h0400, 8'ha5, 8);
    wr(8'hc4, 8'h01);
    ext_stretch = 3'h7;
    xm(1'b1, 16'h03ff, 8'h3c, 8);
    xm(1'b0, 16'h03ff, 8'h00, 8);
    `CHK(xmove_rdata, 8'h3c)
    `CHK(ale_seen, 1'b0)
    xm(1'b0, 16'h0400, 8'h00, 36);
    `CHK(xmove_rdata, 8'ha5)
    ext_stretch = 3'h0;
    xm(1'b1, 16'hffff, 8'h77, 8);
    xm(1'b0, 16'hffff, 8'h00, 8);
    `CHK(xmove_rdata, 8'h77)
    wr(8'hc4, 8'h00);
    xm(1'b0, 16'h03ff, 8'h00, 8);
    `CHK(xmove_rdata, 8'h5a)
    $display("test data move done");
  endtask : t_bus
  task automatic t_power;
    wr(8'h87, 8'h01);
    cnt(16);
    `CHK(nc, 0)
    `CHK(np > 0, 1'b1)
    wake = 1'b1;
    step();
    wake = 1'b0;
    wr(8'h87, 8'h02);
    cnt(16);
    `CHK(nc + np, 0)
    wake = 1'b1;
    step();
    wake = 1'b0;
    // Two divided periods hold exactly two ticks whatever the phase
    for (k = 1; k < 4; k++) begin
      wr(8'hc4, {k[1:0], 6'h00});
      take();
      take();
      cnt(1 << (4 * k - 1));
      `CHK(nc, 2)
    end
    wr(8'hc4, 8'h00);
    $display("test power done");
  endtask : t_power
  ////////////////////////////////////////////////////////////
  initial begin
    {sfr_req, sfr_wr, sfr_direct, sfr_bit, ptr_load, sp_load, wake, xmove_req} = '0;
    {xmove_wr, sfr_bit_idx, ext_stretch, sfr_addr, sfr_wdata, sp_value} = '0;
    {xmove_wdata, ptr_value, xmove_addr} = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_odd();
    t_bus();
    t_power();
    conclude();
  end
endmodule : sfr_and_data_memory_decode_tb_top
`default_nettype wire
